// ==== src/ctm_match.sv ====
`timescale 1ns/10ps
`default_nettype none

module ctm_match (
  input wire logic [15:0] count,
  input wire logic [7:0] per_byte,
  input wire logic [15:0] duty_word,
  output logic per_hit,
  output logic duty_hit,
  output logic at_max
);

  // Period comparator matches the byte against the upper count byte
  // Hit on the last count of block n-1, so the clear that follows gives 256*n
  assign per_hit = (per_byte != 8'h00) && (count[15:8] == per_byte - 8'h01) &&
                   (count[7:0] == 8'hff);
  assign duty_hit = (duty_word != 16'h0000) && (count == duty_word);
  assign at_max = (count == 16'hffff);

endmodule : ctm_match
`default_nettype wire

// ==== src/ctm_pkg.sv ====
`default_nettype none

package ctm_pkg;

  typedef enum logic [1:0] {
    CTM_MODE_COMPARE = 2'b00,
    CTM_MODE_UNDEF = 2'b01,
    CTM_MODE_PWM = 2'b10,
    CTM_MODE_TIMER = 2'b11
  } ctm_mode_type;

  typedef enum logic [1:0] {
    CTM_PIN_A0 = 2'b00,
    CTM_PIN_A1 = 2'b01,
    CTM_PIN_A2 = 2'b10,
    CTM_PIN_A3 = 2'b11
  } ctm_pin_action_type;

endpackage : ctm_pkg

`default_nettype wire

// ==== src/ctm_regs.svh ====
`ifndef CTM_REGS_SVH
`define CTM_REGS_SVH

// ==========================================================
// Register byte addresses
`define CTM_ADDR_CTRL 12'h000
`define CTM_ADDR_MODE 12'h004
`define CTM_ADDR_CNT 12'h008
`define CTM_ADDR_DUTY 12'h00c
`define CTM_ADDR_PER 12'h010
`define CTM_ADDR_FLAGS 12'h014
`define CTM_ADDR_TICK 12'h018

// ==========================================================
// Field positions
`define CTM_CTRL_ENABLE_BIT 3
`define CTM_MODE_FIELD_LSB 6
`define CTM_PIN_ACTION_LSB 4
`define CTM_OUT_CTRL_BIT 3
`define CTM_INVERT_BIT 2
`define CTM_DPX_BIT 1
`define CTM_CLR_SEL_BIT 0
`define CTM_DUTY_FLAG_BIT 0
`define CTM_PER_FLAG_BIT 1

// ==========================================================
// Reset values and timing
`define CTM_CTRL_RESET 8'h00
`define CTM_MODE_RESET 8'h00
`define CTM_DUTY_RESET 16'h0000
`define CTM_PER_RESET 8'h00
`define CTM_TICK_DIV_RESET 16'h0000
`define CTM_FULL_PERIOD 17'h10000

`endif

// ==== src/ctm_tick_div.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ctm_regs.svh"

module ctm_tick_div (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [15:0] divisor,
  output logic tick
);

  logic [15:0] count_ff;

  // Divisor 0 gives a tick every clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_ff <= 16'h0000;
    end else if (!run || count_ff >= divisor) begin
      count_ff <= 16'h0000;
    end else begin
      count_ff <= count_ff + 16'h0001;
    end
  end

  assign tick = run && (count_ff >= divisor);

endmodule : ctm_tick_div
`default_nettype wire

// ==== src/ctm_timer.sv ====
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ctm_regs.svh"

// What this block does
// - Period byte compared to counter upper byte
// - Period 256 times byte; zero gives 65536
// - Zero period byte lets counter overflow
// - Mode field: 00 compare, 11 timer, 10 PWM
// - Clear-select low: period clear, both flags
// - Clear-select high: duty clear, duty flag only
// - Clear-select high never sets period flag outside PWM
// - Zero duty value: overflow, no duty flag
// - Compare mode pin moves on duty match only
// - Pin action: none, low, high, toggle
// - Enable rise loads initial pin level
// - Timer mode like compare, pin undriven
// - PWM ignores clear-select; select picks roles
// - Select 0: period byte, duty word
// - Select 1: period word, duty byte
// - Duty at least period gives full active
// - PWM raises flag per comparator match
// - Output control sets PWM active level
// - PWM counting continues while pin forced
// - PWM pin action: inactive, active, wave
// - Invert bit inverts output pin
// - Enable rise zeroes counter; low holds it

module ctm_timer (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic timer_out,
  output logic timer_out_en
);

  // ==========================================================
  // Reset release
  logic rst_meta_ff;
  logic rst_n_ff;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n_ff <= rst_meta_ff;
    end
  end

  // ==========================================================
  // Register file
  logic enable_ff;
  logic [7:0] mode_reg_ff;
  logic [15:0] duty_value_ff;
  logic [7:0] period_compare_byte_ff;
  logic [15:0] tick_div_ff;
  logic duty_match_flag_ff;
  logic period_match_flag_ff;
  logic [15:0] count_ff;
  logic pin_ff;
  logic enable_d_ff;

  logic wr_en;
  logic addr_ok;
  logic tick;
  logic enable_rise;
  logic per_hit;
  logic duty_hit;
  logic at_max;
  logic clr_flags_duty;
  logic clr_flags_per;
  logic [31:0] nxt_prdata;

  ctm_pkg::ctm_mode_type mode;
  ctm_pkg::ctm_pin_action_type pin_action;
  logic out_ctrl;
  logic out_invert;
  logic dpx;
  logic clr_sel;

  assign mode = ctm_pkg::ctm_mode_type'(mode_reg_ff[`CTM_MODE_FIELD_LSB +: 2]);
  assign pin_action = ctm_pkg::ctm_pin_action_type'(mode_reg_ff[`CTM_PIN_ACTION_LSB +: 2]);
  assign out_ctrl = mode_reg_ff[`CTM_OUT_CTRL_BIT];
  assign out_invert = mode_reg_ff[`CTM_INVERT_BIT];
  assign dpx = mode_reg_ff[`CTM_DPX_BIT];
  assign clr_sel = mode_reg_ff[`CTM_CLR_SEL_BIT];

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] r);
    addr_is = (a == r);
  endfunction : addr_is

  assign addr_ok = addr_is(paddr, `CTM_ADDR_CTRL) || addr_is(paddr, `CTM_ADDR_MODE) ||
                   addr_is(paddr, `CTM_ADDR_CNT) || addr_is(paddr, `CTM_ADDR_DUTY) ||
                   addr_is(paddr, `CTM_ADDR_PER) || addr_is(paddr, `CTM_ADDR_FLAGS) ||
                   addr_is(paddr, `CTM_ADDR_TICK);
  // Zero wait states
  assign pready = psel && penable;
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en = psel && penable && pwrite && addr_ok;

  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      enable_ff <= 1'b0;
      mode_reg_ff <= `CTM_MODE_RESET;
      duty_value_ff <= `CTM_DUTY_RESET;
      period_compare_byte_ff <= `CTM_PER_RESET;
      tick_div_ff <= `CTM_TICK_DIV_RESET;
    end else if (wr_en) begin
      if (addr_is(paddr, `CTM_ADDR_CTRL)) begin
        enable_ff <= pwdata[`CTM_CTRL_ENABLE_BIT];
      end else if (addr_is(paddr, `CTM_ADDR_MODE)) begin
        mode_reg_ff <= pwdata[7:0];
      end else if (addr_is(paddr, `CTM_ADDR_DUTY)) begin
        duty_value_ff <= pwdata[15:0];
      end else if (addr_is(paddr, `CTM_ADDR_PER)) begin
        period_compare_byte_ff <= pwdata[7:0];
      end else if (addr_is(paddr, `CTM_ADDR_TICK)) begin
        tick_div_ff <= pwdata[15:0];
      end
    end
  end

  always_comb begin
    nxt_prdata = 32'h0000_0000;
    if (addr_is(paddr, `CTM_ADDR_CTRL)) begin
      nxt_prdata[`CTM_CTRL_ENABLE_BIT] = enable_ff;
    end else if (addr_is(paddr, `CTM_ADDR_MODE)) begin
      nxt_prdata[7:0] = mode_reg_ff;
    end else if (addr_is(paddr, `CTM_ADDR_CNT)) begin
      nxt_prdata[15:0] = count_ff;
    end else if (addr_is(paddr, `CTM_ADDR_DUTY)) begin
      nxt_prdata[15:0] = duty_value_ff;
    end else if (addr_is(paddr, `CTM_ADDR_PER)) begin
      nxt_prdata[7:0] = period_compare_byte_ff;
    end else if (addr_is(paddr, `CTM_ADDR_FLAGS)) begin
      nxt_prdata[`CTM_DUTY_FLAG_BIT] = duty_match_flag_ff;
      nxt_prdata[`CTM_PER_FLAG_BIT] = period_match_flag_ff;
    end else if (addr_is(paddr, `CTM_ADDR_TICK)) begin
      nxt_prdata[15:0] = tick_div_ff;
    end
  end

  // Read data registered during setup so it is stable in access
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= nxt_prdata;
    end
  end

  // ==========================================================
  // Timer clock and comparators
  ctm_tick_div u_div (
    .clock(clock),
    .rst_n(rst_n_ff),
    .run(enable_ff),
    .divisor(tick_div_ff),
    .tick(tick)
  );

  ctm_match u_match (
    .count(count_ff),
    .per_byte(period_compare_byte_ff),
    .duty_word(duty_value_ff),
    .per_hit(per_hit),
    .duty_hit(duty_hit),
    .at_max(at_max)
  );

  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      enable_d_ff <= 1'b0;
    end else begin
      enable_d_ff <= enable_ff;
    end
  end

  assign enable_rise = enable_ff && !enable_d_ff;

  // Clearing source: period comparator or overflow vs duty comparator
  logic clear_by_per;
  logic clear_now;
  logic per_ev;
  logic duty_ev;

  always_comb begin
    clear_by_per = 1'b1;
    if (mode == ctm_pkg::CTM_MODE_PWM) begin
      clear_by_per = !dpx;
    end else begin
      clear_by_per = !clr_sel;
    end
  end

  // Period byte zero falls back to the 16-bit overflow
  assign clear_now = clear_by_per ? (per_hit || (period_compare_byte_ff == 8'h00 && at_max))
                                  : (duty_hit || (duty_value_ff == 16'h0000 && at_max));
  // Flags raised on the same tick that the match completes
  assign per_ev = tick && (per_hit || (period_compare_byte_ff == 8'h00 && at_max)) &&
                  (mode == ctm_pkg::CTM_MODE_PWM || !clr_sel);
  assign duty_ev = tick && duty_hit;

  // ==========================================================
  // Counter
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      count_ff <= 16'h0000;
    end else if (enable_rise) begin
      count_ff <= 16'h0000;
    end else if (tick) begin
      if (clear_now) begin
        count_ff <= 16'h0000;
      end else begin
        count_ff <= count_ff + 16'h0001;
      end
    end
  end

  // ==========================================================
  // Flags, write one to clear; a new event beats the clear
  assign clr_flags_duty = wr_en && addr_is(paddr, `CTM_ADDR_FLAGS) && pwdata[`CTM_DUTY_FLAG_BIT];
  assign clr_flags_per = wr_en && addr_is(paddr, `CTM_ADDR_FLAGS) && pwdata[`CTM_PER_FLAG_BIT];

  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      duty_match_flag_ff <= 1'b0;
    end else if (duty_ev) begin
      duty_match_flag_ff <= 1'b1;
    end else if (clr_flags_duty) begin
      duty_match_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      period_match_flag_ff <= 1'b0;
    end else if (per_ev) begin
      period_match_flag_ff <= 1'b1;
    end else if (clr_flags_per) begin
      period_match_flag_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Compare-mode pin latch
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      pin_ff <= 1'b0;
    end else if (enable_rise) begin
      pin_ff <= out_ctrl;
    end else if (duty_ev && mode == ctm_pkg::CTM_MODE_COMPARE) begin
      case (pin_action)
        ctm_pkg::CTM_PIN_A1: pin_ff <= 1'b0;
        ctm_pkg::CTM_PIN_A2: pin_ff <= 1'b1;
        ctm_pkg::CTM_PIN_A3: pin_ff <= !pin_ff;
        default: pin_ff <= pin_ff;
      endcase
    end
  end

  // ==========================================================
  // PWM waveform
  logic [16:0] pwm_period;
  logic [16:0] pwm_duty;
  logic [16:0] byte_span;
  logic pwm_active;
  logic nxt_out;

  // Byte value n spans 256*n, zero spans the full 65536
  assign byte_span = (period_compare_byte_ff == 8'h00) ? `CTM_FULL_PERIOD
                     : {1'b0, period_compare_byte_ff, 8'h00};
  assign pwm_period = dpx ? {1'b0, duty_value_ff} : byte_span;
  assign pwm_duty = dpx ? byte_span : {1'b0, duty_value_ff};
  assign pwm_active = (pwm_duty >= pwm_period) || ({1'b0, count_ff} < pwm_duty);

  always_comb begin
    nxt_out = pin_ff;
    if (mode == ctm_pkg::CTM_MODE_PWM) begin
      case (pin_action)
        ctm_pkg::CTM_PIN_A0: nxt_out = !out_ctrl;
        ctm_pkg::CTM_PIN_A1: nxt_out = out_ctrl;
        ctm_pkg::CTM_PIN_A2: nxt_out = pwm_active ? out_ctrl : !out_ctrl;
        default: nxt_out = !out_ctrl;
      endcase
    end
  end

  // Timer mode leaves the pin free for other use
  always_ff @(posedge clock or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      timer_out <= 1'b0;
      timer_out_en <= 1'b0;
    end else begin
      timer_out <= nxt_out ^ out_invert;
      timer_out_en <= (mode == ctm_pkg::CTM_MODE_COMPARE) || (mode == ctm_pkg::CTM_MODE_PWM);
    end
  end

  // ==========================================================
  // Checks
  a_enable_zeroes: assert property (@(posedge clock) disable iff (!rst_n_ff)
    enable_rise |=> count_ff == 16'h0000) else $error("counter not zero after enable");
  a_pin_initial: assert property (@(posedge clock) disable iff (!rst_n_ff)
    enable_rise |=> pin_ff == $past(out_ctrl)) else $error("pin initial level wrong");
  a_no_per_flag: assert property (@(posedge clock) disable iff (!rst_n_ff)
    (mode != ctm_pkg::CTM_MODE_PWM && clr_sel && !period_match_flag_ff && !clr_flags_per)
    |=> !period_match_flag_ff) else $error("period flag with clear-select");
  a_clear_next: assert property (@(posedge clock) disable iff (!rst_n_ff)
    (tick && clear_now && !enable_rise) |=> count_ff == 16'h0000) else $error("no clear");
  a_count_hold: assert property (@(posedge clock) disable iff (!rst_n_ff)
    (!enable_ff && !enable_rise) |=> $stable(count_ff)) else $error("count moved off");
  a_timer_free: assert property (@(posedge clock) disable iff (!rst_n_ff)
    (mode == ctm_pkg::CTM_MODE_TIMER) |=> !timer_out_en) else $error("pin driven");
  a_duty_flag: assert property (@(posedge clock) disable iff (!rst_n_ff)
    duty_ev |=> duty_match_flag_ff) else $error("duty flag lost");
  a_pwm_forced: assert property (@(posedge clock) disable iff (!rst_n_ff)
    (mode == ctm_pkg::CTM_MODE_PWM && pin_action == ctm_pkg::CTM_PIN_A1)
    |=> timer_out == ($past(out_ctrl) ^ $past(out_invert))) else $error("forced level");
  a_compare_pin: assert property (@(posedge clock) disable iff (!rst_n_ff)
    (mode == ctm_pkg::CTM_MODE_COMPARE && !duty_ev && !enable_rise)
    |=> $stable(pin_ff)) else $error("pin moved without duty match");
  // Counter must stay below the period byte block while that byte clears it
  a_period_bound: assert property (@(posedge clock) disable iff (!rst_n_ff)
    (clear_by_per && period_compare_byte_ff != 8'h00 && !wr_en &&
     count_ff[15:8] < period_compare_byte_ff)
    |=> count_ff[15:8] < period_compare_byte_ff) else $error("counter passed period");

endmodule : ctm_timer
`default_nettype wire

// ==== verif/compact_timer_modes_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ctm_regs.svh"

module compact_timer_modes_tb_top;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic timer_out;
  logic timer_out_en;
  logic level;
  logic [16:0] high_len;
  logic [16:0] period_len;
  logic [31:0] rd;
  logic err;
  logic seen;
  int bad_count = 0;
  int samples_checked = 0;

  always #12.5 clock = ~clock;

  ctm_timer dut (.clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_out(timer_out), .timer_out_en(timer_out_en));

  ctm_pin_load load (.clock(clock), .pin(timer_out), .pin_en(timer_out_en), .level(level),
    .high_len(high_len), .period_len(period_len));

  // ==========================================================
  // Shared tasks
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  // Entered just after a rising edge; leaves one idle edge so psel never toggles twice
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  // Mode changes only while disabled, enable raised last
  task automatic cfg(input logic [1:0] mode, input logic [1:0] pa, input logic [3:0] bits,
      input logic [7:0] per, input logic [15:0] duty);
    apb(1'b1, `CTM_ADDR_CTRL, 32'h0);
    apb(1'b1, `CTM_ADDR_MODE, {24'h0, mode, pa, bits});
    apb(1'b1, `CTM_ADDR_DUTY, {16'h0, duty});
    apb(1'b1, `CTM_ADDR_PER, {24'h0, per});
    apb(1'b1, `CTM_ADDR_FLAGS, 32'h3);
    apb(1'b1, `CTM_ADDR_CTRL, 32'h8);
  endtask : cfg

  task automatic pin_hold(input logic exp);
    repeat (5) @(posedge clock);
    seen = 1'b0;
    repeat (300) begin
      @(posedge clock);
      seen = seen | (level !== exp);
    end
  endtask : pin_hold

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    logic [11:0] ra [7] = '{`CTM_ADDR_CTRL, `CTM_ADDR_MODE, `CTM_ADDR_CNT, `CTM_ADDR_DUTY,
      `CTM_ADDR_PER, `CTM_ADDR_FLAGS, `CTM_ADDR_TICK};
    foreach (ra[k]) begin
      apb(1'b0, ra[k], 32'h0);
      chk(rd, 32'h0, "reset value");
    end
    apb(1'b1, `CTM_ADDR_PER, 32'h1a5);
    apb(1'b0, `CTM_ADDR_PER, 32'h0);
    chk(rd, 32'ha5, "period byte width");
    apb(1'b0, 12'h01c, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    $display("test regs done");
  endtask : t_regs

  task automatic t_cmp;
    logic [31:0] pin_exp [4] = '{32'h0, 32'h0, 32'h1, 32'h0};
    for (int i = 0; i < 4; i++) begin
      cfg(ctm_pkg::CTM_MODE_COMPARE, i[1:0], {i[0], 3'b000}, 8'h01, 16'h0010);
      repeat (4) @(posedge clock);
      chk({31'h0, timer_out}, {31'h0, i[0]}, "initial level");
      repeat (30) @(posedge clock);
      chk({31'h0, timer_out}, pin_exp[i], "pin after duty match");
      repeat (235) @(posedge clock);
      apb(1'b0, `CTM_ADDR_FLAGS, 32'h0);
      chk(rd, 32'h3, "both flags");
      apb(1'b0, `CTM_ADDR_CNT, 32'h0);
      chk({8'h0, rd[31:8]}, 32'h0, "counter wrapped at 256");
    end
    $display("test compare done");
  endtask : t_cmp

  task automatic t_clr;
    cfg(ctm_pkg::CTM_MODE_COMPARE, 2'b11, 4'b0001, 8'h01, 16'h0180);
    repeat (300) @(posedge clock);
    chk({31'h0, timer_out}, 32'h0, "period match leaves pin");
    repeat (120) @(posedge clock);
    chk({31'h0, timer_out}, 32'h1, "duty match toggles pin");
    apb(1'b0, `CTM_ADDR_FLAGS, 32'h0);
    chk(rd, 32'h1, "duty flag only");
    apb(1'b0, `CTM_ADDR_CNT, 32'h0);
    chk({31'h0, rd < 32'h80}, 32'h1, "cleared by duty match");
    $display("test clear select done");
  endtask : t_clr

  task automatic t_ovf;
    cfg(ctm_pkg::CTM_MODE_COMPARE, 2'b00, 4'b0000, 8'h00, 16'h0010);
    repeat (600) @(posedge clock);
    apb(1'b0, `CTM_ADDR_FLAGS, 32'h0);
    chk(rd, 32'h1, "zero byte gives no period match");
    apb(1'b0, `CTM_ADDR_CNT, 32'h0);
    chk({31'h0, rd > 32'h1ff}, 32'h1, "zero byte runs past 256");
    cfg(ctm_pkg::CTM_MODE_COMPARE, 2'b11, 4'b0001, 8'h01, 16'h0000);
    repeat (600) @(posedge clock);
    apb(1'b0, `CTM_ADDR_FLAGS, 32'h0);
    chk(rd, 32'h0, "zero duty value raises no flag");
    apb(1'b0, `CTM_ADDR_CNT, 32'h0);
    chk({31'h0, rd > 32'h1ff}, 32'h1, "zero duty value runs on");
    chk({31'h0, timer_out}, 32'h0, "no duty match keeps pin");
    // Divisor 3: one timer clock every fourth clock, about 100 in 400
    apb(1'b1, `CTM_ADDR_TICK, 32'h3);
    cfg(ctm_pkg::CTM_MODE_COMPARE, 2'b00, 4'b0000, 8'h01, 16'h0000);
    repeat (400) @(posedge clock);
    apb(1'b0, `CTM_ADDR_CNT, 32'h0);
    chk({31'h0, rd >= 32'h60 && rd <= 32'h68}, 32'h1, "tick every fourth clock");
    apb(1'b1, `CTM_ADDR_TICK, 32'h0);
    $display("test overflow done");
  endtask : t_ovf

  task automatic t_tmr;
    cfg(ctm_pkg::CTM_MODE_TIMER, 2'b11, 4'b1000, 8'h01, 16'h0010);
    repeat (270) @(posedge clock);
    chk({31'h0, timer_out_en}, 32'h0, "pin released");
    chk({31'h0, level}, 32'h1, "pull-up seen");
    apb(1'b0, `CTM_ADDR_FLAGS, 32'h0);
    chk(rd, 32'h3, "timer flags");
    $display("test timer done");
  endtask : t_tmr

  task automatic t_pwm;
    cfg(ctm_pkg::CTM_MODE_PWM, 2'b10, 4'b1001, 8'h01, 16'h0040);
    repeat (800) @(posedge clock);
    chk({15'h0, high_len}, 32'h40, "pwm duty");
    chk({15'h0, period_len}, 32'h100, "pwm period");
    apb(1'b0, `CTM_ADDR_FLAGS, 32'h0);
    chk(rd, 32'h3, "pwm flags");
    cfg(ctm_pkg::CTM_MODE_PWM, 2'b10, 4'b1110, 8'h01, 16'h0080);
    pin_hold(1'b0);
    chk({31'h0, seen}, 32'h0, "full duty inverted");
    for (int p = 0; p < 2; p++) begin
      cfg(ctm_pkg::CTM_MODE_PWM, p[1:0], 4'b0000, 8'h01, 16'h0040);
      pin_hold(~p[0]);
      chk({31'h0, seen}, 32'h0, "forced pin level");
      apb(1'b0, `CTM_ADDR_FLAGS, 32'h0);
      chk(rd, 32'h3, "flags while forced");
    end
    $display("test pwm done");
  endtask : t_pwm

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_regs();
    t_cmp();
    t_clr();
    t_ovf();
    t_tmr();
    t_pwm();
    close_out();
  end

  // Whole run is about 5400 clocks
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    close_out();
  end
endmodule : compact_timer_modes_tb_top

`default_nettype wire

// ==== verif/ctm_pin_load.sv ====
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Load on the timer pin, pulled up whenever the pin is released
module ctm_pin_load (
  input wire logic clock,
  input wire logic pin,
  input wire logic pin_en,
  output logic level,
  output logic [16:0] high_len,
  output logic [16:0] period_len
);
  logic last_ff = 1'b0;
  logic [16:0] hi_cnt_ff = 17'h00000;
  logic [16:0] per_cnt_ff = 17'h00000;

  assign level = pin_en ? pin : 1'b1;

  // Lengths in clocks; period latched at each rising edge of level, high time at each falling edge
  always_ff @(posedge clock) begin
    last_ff <= level;
    hi_cnt_ff <= level ? hi_cnt_ff + 17'h00001 : 17'h00000;
    per_cnt_ff <= per_cnt_ff + 17'h00001;
    if (level && !last_ff) begin
      period_len <= per_cnt_ff;
      per_cnt_ff <= 17'h00001;
    end
    if (!level && last_ff) begin
      high_len <= hi_cnt_ff;
    end
  end
endmodule : ctm_pin_load

`default_nettype wire
